//--- design/smbus_flags.sv
// Function
// - master flag set on generated start, cleared on stop or lost arbitration
// - transmit flag set on start or early data write; cleared otherwise
// - start flag set on received start plus address; only software clears
// - writing start flag 1 requests a start; 0 clears the flag
// - stop flag write 1 sends stop after ack; cleared when stop generated
// - stop flag set on slave stop or arbitration lost by stop
// - ack request set after received byte when hardware ack off; cleared per ack
// - arbitration lost on unwanted repeated start while start flag low
// - arbitration lost when scl low during stop or repeated start
// - arbitration lost when sda low while sending a one, not ack bits
// - arbitration lost flag cleared whenever event flag is cleared
// - ack bit inverts incoming ack line: line low (ack) reads 1, line high (nack) reads 0
// - event flag set on start, loss, byte done, address, stop
// - while event flag set, hold scl low and stall the interface
// - event flag write 0 clears and advances; write 1 forces interrupt
// - register at 0xC0 page F, bit addressable, all bits reset zero
// - as receiver drive ack bit on sda at once; scl held until cleared
// - software ack: clearing event without writing ack sends nack
// - after nacked slave address ignore slave events until next start
// - hardware ack: refused address raises no interrupt, no ack request
module smbus_flags
  import smbus_flags_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // sfr port
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // configuration
  input wire logic auto_response_enable,
  // bus engine events
  input wire logic ev_start_gen,
  input wire logic ev_stop_gen,
  input wire logic ev_start_det,
  input wire logic ev_rstart_det,
  input wire logic ev_stop_det,
  input wire logic ev_addr_rcvd,
  input wire logic ev_addr_match,
  input wire logic ev_byte_rcvd,
  input wire logic ev_byte_sent_acked,
  input wire logic ev_ack_cycle,
  input wire logic ack_in,
  input wire logic ev_data_written,
  input wire logic ev_frame_begin,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic gen_stop_or_rstart,
  input wire logic tx_one_data_bit,
  // to bus engine
  output logic start_req,
  output logic stop_req,
  output logic advance,
  output logic stall,
  output logic scl_hold_low,
  output logic ack_out,
  output logic slave_ignore
);
  sfr_access_if acc();
  sfr_decoder u_dec (
    .sfr_addr(sfr_addr),
    .sfr_page(sfr_page),
    .sfr_wr(sfr_wr),
    .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_sel(sfr_bit_sel),
    .sfr_wdata(sfr_wdata),
    .acc(acc)
  );

  function automatic logic wr_bit(input logic en, input logic [7:0] m, input int b);
    wr_bit = en && m[b];
  endfunction : wr_bit

  logic master_q, tx_q, sta_q, sto_q, ackrq_q, arbl_q, ack_q, evt_q;
  logic ack_written_q, ignore_q;
  logic wr_sta, wr_sto, wr_ack, wr_evt;
  logic evt_clear, arb_lost, arb_by_stop, addr_refused, slave_ev;

  always_comb begin
    wr_sta = wr_bit(acc.wr_en, acc.wr_mask, START_BIT);
    wr_sto = wr_bit(acc.wr_en, acc.wr_mask, STOP_BIT);
    wr_ack = wr_bit(acc.wr_en, acc.wr_mask, ACK_BIT);
    wr_evt = wr_bit(acc.wr_en, acc.wr_mask, EVT_BIT);
    evt_clear = wr_evt && !acc.wr_data[EVT_BIT];
    arb_lost = (master_q && ev_rstart_det && !sta_q)
      || (gen_stop_or_rstart && !scl_in)
      || (tx_one_data_bit && !sda_in);
    arb_by_stop = arb_lost && ev_stop_det;
    addr_refused = ev_addr_rcvd && auto_response_enable && !ev_addr_match;
    slave_ev = !ignore_q && !master_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // role flags
  always_ff @(posedge clk) begin
    if (rst) begin
      master_q <= 1'b0;
    end else if (ce) begin
      if (ev_start_gen) begin
        master_q <= 1'b1;
      end else if (ev_stop_gen || arb_lost) begin
        master_q <= 1'b0;
      end
    end
  end

  // buffer write is a one-cycle pulse; remember it until the frame begins
  logic data_written_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      data_written_q <= 1'b0;
    end else if (ce) begin
      if (ev_frame_begin) begin
        data_written_q <= 1'b0;
      end else if (ev_data_written) begin
        data_written_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_q <= 1'b0;
    end else if (ce) begin
      if (ev_start_gen) begin
        tx_q <= 1'b1;
      end else if (ev_start_det || arb_lost) begin
        tx_q <= 1'b0;
      end else if (ev_frame_begin) begin
        tx_q <= ev_data_written || data_written_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start and stop flags
  always_ff @(posedge clk) begin
    if (rst) begin
      sta_q <= 1'b0;
    end else if (ce) begin
      // start flag; hardware set beats software clear
      if (ev_addr_rcvd && slave_ev && !addr_refused) begin
        sta_q <= 1'b1;
      end else if (wr_sta) begin
        sta_q <= acc.wr_data[START_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sto_q <= 1'b0;
    end else if (ce) begin
      if ((ev_stop_det && !master_q && !ignore_q) || arb_by_stop) begin
        sto_q <= 1'b1;
      end else if (ev_stop_gen) begin
        sto_q <= 1'b0;
      end else if (wr_sto) begin
        sto_q <= acc.wr_data[STOP_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge handling
  always_ff @(posedge clk) begin
    if (rst) begin
      ackrq_q <= 1'b0;
    end else if (ce) begin
      // ack request only with software ack
      // address byte needs a software answer too
      if ((ev_byte_rcvd || (ev_addr_rcvd && slave_ev)) && !auto_response_enable) begin
        ackrq_q <= 1'b1;
      end else if (ev_ack_cycle) begin
        ackrq_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      ack_written_q <= 1'b0;
    end else if (ce) begin
      if (ev_ack_cycle && tx_q) begin
        ack_q <= !ack_in;
      end else if (wr_ack) begin
        ack_q <= acc.wr_data[ACK_BIT];
      end else if (evt_clear && ackrq_q && !ack_written_q) begin
        ack_q <= 1'b0;
      end
      if (ev_byte_rcvd || ev_addr_rcvd) begin
        ack_written_q <= 1'b0;
      end else if (wr_ack) begin
        ack_written_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ignore_q <= 1'b0;
    end else if (ce) begin
      if (ev_start_det || ev_rstart_det) begin
        ignore_q <= 1'b0;
      end else if (addr_refused
                   || (evt_clear && !ev_addr_rcvd && sta_q && !master_q
                       && ackrq_q && !ack_q && !(wr_ack && acc.wr_data[ACK_BIT]))) begin
        ignore_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration and event flags
  always_ff @(posedge clk) begin
    if (rst) begin
      arbl_q <= 1'b0;
    end else if (ce) begin
      if (arb_lost) begin
        arbl_q <= 1'b1;
      end else if (evt_clear) begin
        arbl_q <= 1'b0;
      end
    end
  end

  logic evt_set;
  always_comb begin
    evt_set = ev_start_gen || arb_lost || ev_byte_sent_acked
      || (ev_byte_rcvd && (master_q || !ignore_q))
      || (ev_addr_rcvd && slave_ev && !addr_refused)
      || (ev_stop_det && slave_ev);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      evt_q <= 1'b0;
    end else if (ce) begin
      // only software clears; hardware set wins
      if (evt_set) begin
        evt_q <= 1'b1;
      end else if (wr_evt) begin
        evt_q <= acc.wr_data[EVT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to engine and sfr
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= CTRL_RESET;
      sfr_hit <= 1'b0;
      start_req <= 1'b0;
      stop_req <= 1'b0;
      advance <= 1'b0;
      stall <= 1'b0;
      scl_hold_low <= 1'b0;
      ack_out <= 1'b0;
      slave_ignore <= 1'b0;
    end else if (ce) begin
      sfr_rdata <= {master_q, tx_q, sta_q, sto_q, ackrq_q, arbl_q, ack_q, evt_q};
      sfr_hit <= acc.sel;
      start_req <= sta_q && !evt_q;
      stop_req <= sto_q && master_q;
      advance <= evt_clear && !evt_set;
      stall <= evt_set || (evt_q && !evt_clear);
      scl_hold_low <= evt_set || (evt_q && !evt_clear);
      ack_out <= wr_ack ? acc.wr_data[ACK_BIT] : ack_q;
      slave_ignore <= ignore_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_master_set;
    @(posedge clk) disable iff (rst) ce && ev_start_gen |=> master_q;
  endproperty
  a_master_set: assert property (p_master_set) else $error("master flag not set");
  property p_arbl_clr;
    @(posedge clk) disable iff (rst) ce && evt_clear && !arb_lost |=> !arbl_q;
  endproperty
  a_arbl_clr: assert property (p_arbl_clr) else $error("loss flag not cleared");
  property p_evt_set;
    @(posedge clk) disable iff (rst) ce && evt_set |=> evt_q;
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("event flag lost");
  property p_hold;
    @(posedge clk) disable iff (rst) ce && evt_q && $past(evt_q) && !evt_clear
      |=> scl_hold_low && stall;
  endproperty
  a_hold: assert property (p_hold) else $error("scl not held");
  property p_sto_clr;
    @(posedge clk) disable iff (rst) ce && ev_stop_gen && !arb_by_stop
      && !(ev_stop_det && !master_q) |=> !sto_q;
  endproperty
  a_sto_clr: assert property (p_sto_clr) else $error("stop flag stuck");
  property p_ackrq_auto;
    @(posedge clk) disable iff (rst) auto_response_enable && !ackrq_q && ce
      && !ev_ack_cycle |=> !ackrq_q;
  endproperty
  a_ackrq_auto: assert property (p_ackrq_auto) else $error("ack request with auto ack");
  property p_ack_in;
    @(posedge clk) disable iff (rst) ce && ev_ack_cycle && tx_q ##1 1'b1
      |-> ack_q == !$past(ack_in);
  endproperty
  a_ack_in: assert property (p_ack_in) else $error("ack bit wrong");
  property p_ro;
    @(posedge clk) disable iff (rst) ce && !arb_lost && !evt_clear
      |=> arbl_q == $past(arbl_q);
  endproperty
  a_ro: assert property (p_ro) else $error("loss flag changed");
  c_start: cover property (@(posedge clk) ce && ev_start_gen ##[1:20] evt_q);
  c_arb: cover property (@(posedge clk) ce && arb_lost ##1 arbl_q);
  c_stop: cover property (@(posedge clk) sto_q ##[1:50] !sto_q);
endmodule : smbus_flags

//--- design/smbus_flags_pkg.sv
package smbus_flags_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'hC0;
  localparam logic [3:0] CTRL_PAGE = 4'hF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int MASTER_BIT = 7;
  localparam int TXMODE_BIT = 6;
  localparam int START_BIT = 5;
  localparam int STOP_BIT = 4;
  localparam int ACKRQ_BIT = 3;
  localparam int ARBL_BIT = 2;
  localparam int ACK_BIT = 1;
  localparam int EVT_BIT = 0;
  localparam logic [7:0] SW_WRITABLE_MASK = 8'h33;
  typedef enum logic [1:0] {
    WR_NONE,
    WR_BYTE,
    WR_BIT
  } wr_kind_type;
endpackage : smbus_flags_pkg

//--- design/sfr_access_if.sv
interface sfr_access_if;
  import smbus_flags_pkg::*;
  logic wr_en;
  logic [7:0] wr_mask;
  logic [7:0] wr_data;
  logic sel;
  modport decoder(output wr_en, output wr_mask, output wr_data, output sel);
  modport core(input wr_en, input wr_mask, input wr_data, input sel);
endinterface : sfr_access_if

//--- design/sfr_decoder.sv
module sfr_decoder
  import smbus_flags_pkg::*;
(
  // sfr port
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic [7:0] sfr_wdata,
  // to core
  sfr_access_if.decoder acc
);
  wr_kind_type kind;
  always_comb begin
    acc.sel = (sfr_addr == CTRL_ADDR) && (sfr_page == CTRL_PAGE);
    kind = WR_NONE;
    if (acc.sel && sfr_wr) begin
      kind = WR_BYTE;
    end else if (acc.sel && sfr_bit_wr) begin
      kind = WR_BIT;
    end
    case (kind)
      WR_BYTE: acc.wr_mask = 8'hFF;
      WR_BIT: acc.wr_mask = 8'h01 << sfr_bit_sel;
      default: acc.wr_mask = 8'h00;
    endcase
    acc.wr_en = (kind != WR_NONE);
    // bit writes carry their value in bit 0, spread to all lanes
    acc.wr_data = (kind == WR_BIT) ? {8{sfr_wdata[0]}} : sfr_wdata;
  end
endmodule : sfr_decoder

//--- test/bus_far_side.sv
module bus_far_side (
  // clock
  input wire logic clk,
  // device stall
  input wire logic scl_hold_low,
  // event pulses and line levels
  output logic [11:0] ev,
  output logic ack_in,
  output logic scl_in,
  output logic sda_in,
  output logic gen_stop_or_rstart,
  output logic tx_one_data_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // {ack, scl, sda, stop or rstart window, one-bit window}; idle lines float high
  logic [4:0] lvq = 5'b11100;
  initial ev = '0;
  assign scl_in = lvq[3] & ~scl_hold_low;
  assign {ack_in, sda_in, gen_stop_or_rstart, tx_one_data_bit} = {lvq[4], lvq[2:0]};
  task automatic pulse(input logic [11:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = '0;
  endtask : pulse
  task automatic lines(input logic [4:0] l);
    @(negedge clk);
    lvq = l;
  endtask : lines
endmodule : bus_far_side

//--- test/testbench.sv
module testbench
  import smbus_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s: expected %h seen %h", nm, e, a); end end
  localparam logic [11:0] ST_G = 12'h800, SP_G = 12'h400, ST_D = 12'h200, RS_D = 12'h100;
  localparam logic [11:0] SP_D = 12'h080, AD_R = 12'h040, AD_M = 12'h020, BY_R = 12'h010;
  localparam logic [11:0] BY_S = 12'h008, AK_C = 12'h004, DW = 12'h002, FB = 12'h001;
  localparam logic [4:0] DFLT = 5'b11100;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, sfr_wr = 1'b0, sfr_bit_wr = 1'b0;
  logic auto_response_enable = 1'b0, hit;
  logic [7:0] sfr_addr = CTRL_ADDR, sfr_wdata = 8'h00, sfr_rdata;
  logic [3:0] sfr_page = CTRL_PAGE;
  logic [2:0] sfr_bit_sel = 3'h0;
  logic [11:0] ev;
  logic ev_start_gen, ev_stop_gen, ev_start_det, ev_rstart_det, ev_stop_det, ev_addr_rcvd;
  logic ev_addr_match, ev_byte_rcvd, ev_byte_sent_acked, ev_ack_cycle, ev_data_written;
  logic ev_frame_begin, ack_in, scl_in, sda_in, gen_stop_or_rstart, tx_one_data_bit, sfr_hit;
  logic start_req, stop_req, advance, stall, scl_hold_low, ack_out, slave_ignore;
  int fail_count = 0;
  int n_checks = 0;
  typedef struct {string nm; logic auto_on; logic [4:0] lv; logic [11:0] e1, e2;
    logic [7:0] mask, exp;} row_type;
  row_type rows[] = '{
    '{"start_gen", 1'b0, DFLT, ST_G, 12'h000, 8'hFF, 8'hC1},
    '{"addr_after_start", 1'b0, DFLT, ST_D, AD_R, 8'hE5, 8'h21},
    '{"byte_rcvd_sw", 1'b0, DFLT, BY_R, 12'h000, 8'hFF, 8'h09},
    '{"byte_rcvd_hw", 1'b1, DFLT, BY_R, 12'h000, 8'h08, 8'h00},
    '{"ack_low", 1'b0, 5'b01100, ST_G, AK_C | BY_S, 8'h43, 8'h43},
    '{"sda_low_tx1", 1'b0, 5'b11001, 12'h000, 12'h000, 8'h85, 8'h05},
    '{"scl_low_stop", 1'b0, 5'b10110, 12'h000, 12'h000, 8'h85, 8'h05},
    '{"rstart_unwanted", 1'b0, DFLT, ST_G, RS_D, 8'h84, 8'h04},
    '{"early_write", 1'b0, DFLT, DW, FB, 8'h40, 8'h40},
    '{"late_frame", 1'b0, DFLT, ST_G, FB, 8'h40, 8'h00}};
  assign {ev_start_gen, ev_stop_gen, ev_start_det, ev_rstart_det, ev_stop_det, ev_addr_rcvd,
    ev_addr_match, ev_byte_rcvd, ev_byte_sent_acked, ev_ack_cycle, ev_data_written,
    ev_frame_begin} = ev;
  always #10 clk = ~clk;
  smbus_flags smbus_flags_i (.clk, .rst, .ce, .sfr_addr, .sfr_page, .sfr_wr, .sfr_bit_wr,
    .sfr_bit_sel, .sfr_wdata, .sfr_rdata, .sfr_hit, .auto_response_enable, .ev_start_gen,
    .ev_stop_gen, .ev_start_det, .ev_rstart_det, .ev_stop_det, .ev_addr_rcvd, .ev_addr_match,
    .ev_byte_rcvd, .ev_byte_sent_acked, .ev_ack_cycle, .ack_in, .ev_data_written,
    .ev_frame_begin, .scl_in, .sda_in, .gen_stop_or_rstart, .tx_one_data_bit, .start_req,
    .stop_req, .advance, .stall, .scl_hold_low, .ack_out, .slave_ignore);
  bus_far_side bus_far_side_i (.clk, .scl_hold_low, .ev, .ack_in, .scl_in, .sda_in,
    .gen_stop_or_rstart, .tx_one_data_bit);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic do_reset(input logic a);
    @(negedge clk);
    rst = 1'b1;
    auto_response_enable = a;
    repeat (4) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset
  task automatic fire(input logic [11:0] m);
    bus_far_side_i.pulse(m);
    @(negedge clk);
  endtask : fire
  task automatic wr(input logic bitw, input logic [2:0] sel, input logic [7:0] d);
    @(negedge clk);
    sfr_bit_wr = bitw;
    sfr_wr = ~bitw;
    sfr_bit_sel = sel;
    sfr_wdata = d;
    @(negedge clk);
    sfr_bit_wr = 1'b0;
    sfr_wr = 1'b0;
  endtask : wr
  // registered requests may land one cycle after the write edge
  task automatic win(input string nm, ref logic s);
    hit = s;
    @(negedge clk);
    hit |= s;
    `CHK(nm, 1'b1, hit)
  endtask : win
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #50us;
    fail_count++;
    end_of_test();
  end
  initial begin
    foreach (rows[i]) begin
      do_reset(rows[i].auto_on);
      bus_far_side_i.lines(rows[i].lv);
      bus_far_side_i.pulse(rows[i].e1);
      bus_far_side_i.pulse(rows[i].e2);
      bus_far_side_i.lines(DFLT);
      @(negedge clk);
      `CHK(rows[i].nm, rows[i].exp, sfr_rdata & rows[i].mask)
      $display("test %s done", rows[i].nm);
    end
    do_reset(1'b0);
    @(negedge clk);
    `CHK("rdata", CTRL_RESET, sfr_rdata)
    `CHK("sfr_hit", 1'b1, sfr_hit)
    wr(1'b0, 3'h0, 8'hFF);
    @(negedge clk);
    `CHK("rdata", 8'h33, sfr_rdata)
    `CHK("stall", 1'b1, stall)
    sfr_page = 4'h0;
    wr(1'b0, 3'h0, 8'h00);
    `CHK("sfr_hit", 1'b0, sfr_hit)
    sfr_page = CTRL_PAGE;
    @(negedge clk);
    `CHK("rdata", 8'h33, sfr_rdata)
    $display("test registers done");
    do_reset(1'b0);
    fire(ST_G);
    `CHK("scl_hold_low", 1'b1, scl_hold_low)
    wr(1'b1, 3'h5, 8'h01);
    `CHK("start_req", 1'b0, start_req)
    wr(1'b1, 3'h4, 8'h01);
    win("stop_req", stop_req);
    wr(1'b1, 3'h0, 8'h00);
    win("advance", advance);
    `CHK("start_req", 1'b1, start_req)
    `CHK("stall", 1'b0, stall)
    fire(SP_G);
    `CHK("rdata", 8'h00, sfr_rdata & 8'h90)
    $display("test master walk done");
    do_reset(1'b0);
    bus_far_side_i.lines(5'b11001);
    bus_far_side_i.lines(DFLT);
    @(negedge clk);
    `CHK("rdata", 8'h05, sfr_rdata & 8'h05)
    wr(1'b1, 3'h0, 8'h00);
    @(negedge clk);
    `CHK("rdata", 8'h00, sfr_rdata & 8'h05)
    $display("test arb clear done");
    do_reset(1'b0);
    fire(BY_R);
    wr(1'b1, 3'h1, 8'h01);
    `CHK("ack_out", 1'b1, ack_out)
    `CHK("scl_hold_low", 1'b1, scl_hold_low)
    wr(1'b1, 3'h0, 8'h00);
    fire(AK_C);
    `CHK("rdata", 8'h00, sfr_rdata & 8'h08)
    fire(BY_R);
    wr(1'b1, 3'h0, 8'h00);
    @(negedge clk);
    `CHK("ack_out", 1'b0, ack_out)
    $display("test software ack done");
    do_reset(1'b0);
    fire(ST_D);
    fire(AD_R);
    wr(1'b1, 3'h0, 8'h00);
    fire(AK_C);
    `CHK("slave_ignore", 1'b1, slave_ignore)
    fire(ST_D);
    `CHK("slave_ignore", 1'b0, slave_ignore)
    do_reset(1'b1);
    fire(ST_D);
    fire(AD_R);
    `CHK("rdata", 8'h00, sfr_rdata & 8'h09)
    `CHK("slave_ignore", 1'b1, slave_ignore)
    fire(ST_D);
    fire(AD_R | AD_M);
    wr(1'b1, 3'h0, 8'h00);
    fire(SP_D);
    `CHK("rdata", 8'h10, sfr_rdata & 8'h10)
    $display("test slave done");
    end_of_test();
  end
endmodule : testbench
